//--- src/dma_map.vh
`ifndef DMA_MAP_VH
`define DMA_MAP_VH
// register byte offsets, channel block stride 0x20
`define CH_STRIDE 8'h20
`define REG_CTRL 8'h00
`define REG_SRC_START 8'h04
`define REG_DST_START 8'h08
`define REG_RELOAD 8'h0c
`define REG_PTR 8'h10
`define REG_CNT 8'h14
`define REG_IRQ_STAT 8'h40
`define REG_IRQ_EN 8'h44
`define REG_IRQ_CLR 8'h48
// control register bit positions
`define BIT_ENABLE 0
`define BIT_PENDING 1
`define BIT_SRC_FWD 2
`define BIT_DST_FWD 3
`define BIT_UNIT16 4
`define CTRL_W 5
// sequencer states
`define ST_IDLE 3'h0
`define ST_LOAD 3'h1
`define ST_RD0 3'h2
`define ST_RD1 3'h3
`define ST_WR 3'h4
`endif

//--- src/dma_irq.v
`timescale 1ns/1ps
module dma_irq #(
  parameter N = 2
) (
  input wire pclk,
  input wire presetn,
  input wire [N-1:0] evt,
  input wire en_we,
  input wire clr_we,
  input wire [N-1:0] wdata,
  output wire [N-1:0] status,
  output wire [N-1:0] enable,
  output wire irq
);
  reg [N-1:0] stat_q;
  reg [N-1:0] en_q;

  // sticky status; an event in the clearing cycle survives the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= {N{1'b0}};
      en_q <= {N{1'b0}};
    end else begin
      stat_q <= (stat_q & ~(clr_we ? wdata : {N{1'b0}})) | evt;
      if (en_we) begin
        en_q <= wdata;
      end
    end
  end

  assign status = stat_q;
  assign enable = en_q;
  assign irq = |(stat_q & en_q);
endmodule

//--- src/dma_chan.v
`timescale 1ns/1ps
`include "dma_map.vh"
module dma_chan #(
  parameter AW = 20,
  parameter CW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire ctrl_we,
  input wire src_we,
  input wire dst_we,
  input wire reload_we,
  input wire [31:0] wdata,
  input wire req_evt,
  input wire xfer_start,
  input wire xfer_done,
  output wire [`CTRL_W-1:0] ctrl,
  output wire [AW-1:0] src_start,
  output wire [AW-1:0] dst_start,
  output wire [CW-1:0] reload,
  output wire [AW-1:0] ptr,
  output wire [CW-1:0] cnt,
  output wire fin
);
  reg en_q, pend_q, sfwd_q, dfwd_q, u16_q, arm_q;
  reg [AW-1:0] src_q, dst_q, ptr_q;
  reg [CW-1:0] rel_q, cnt_q;
  wire [AW-1:0] step;

  assign step = u16_q ? {{(AW-2){1'b0}}, 2'b10} : {{(AW-1){1'b0}}, 1'b1};
  // the final unit of a block ends the channel
  assign fin = xfer_done & (cnt_q == {{(CW-1){1'b0}}, 1'b1});

  // control bits and start values
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      sfwd_q <= 1'b0;
      dfwd_q <= 1'b0;
      u16_q <= 1'b0;
      arm_q <= 1'b0;
      src_q <= {AW{1'b0}};
      dst_q <= {AW{1'b0}};
      rel_q <= {CW{1'b0}};
    end else begin
      if (src_we) src_q <= wdata[AW-1:0];
      if (dst_we) dst_q <= wdata[AW-1:0];
      if (reload_we) rel_q <= wdata[CW-1:0];
      if (ctrl_we) begin
        en_q <= wdata[`BIT_ENABLE];
        sfwd_q <= wdata[`BIT_SRC_FWD];
        dfwd_q <= wdata[`BIT_DST_FWD];
        u16_q <= wdata[`BIT_UNIT16];
        arm_q <= wdata[`BIT_ENABLE];
      end else begin
        if (fin) en_q <= 1'b0;
        if (xfer_start) arm_q <= 1'b0;
      end
    end
  end

  // pending flag: hardware set beats any clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
    end else if (req_evt) begin
      pend_q <= 1'b1;
    end else if (xfer_start) begin
      pend_q <= 1'b0;
    end else if (ctrl_we && !wdata[`BIT_PENDING]) begin
      pend_q <= 1'b0;
    end
  end

  // working pointer and counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= {AW{1'b0}};
      cnt_q <= {CW{1'b0}};
    end else if (xfer_start && arm_q) begin
      ptr_q <= (sfwd_q || !dfwd_q) ? src_q : dst_q;
      cnt_q <= rel_q;
    end else if (xfer_done) begin
      ptr_q <= ptr_q + step;
      cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  assign ctrl = {u16_q, dfwd_q, sfwd_q, pend_q, en_q};
  assign src_start = src_q;
  assign dst_start = dst_q;
  assign reload = rel_q;
  assign ptr = ptr_q;
  assign cnt = cnt_q;
endmodule

//--- src/dma_top.v
// How it works
// - first transfer after enable loads pointer from the forward start register.
// - that same transfer loads the counter from its reload register.
// - writing enable 1 while already set repeats both reloads.
// - 16-bit unit from odd source reads source then source+1, then writes.
// - every request sets pending regardless of enable.
// - enabled channel clears pending just before its transfer begins.
// - software writing pending 1 is ignored; writing 0 clears it.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "dma_map.vh"
module dma_top #(
  parameter AW = 20,
  parameter CW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [1:0] req_evt,
  output reg mem_req,
  output reg mem_we,
  output reg mem_wide,
  output reg [AW-1:0] mem_addr,
  output reg [15:0] mem_wdata,
  input wire [15:0] mem_rdata,
  input wire mem_ack,
  output wire irq
);
  localparam NCH = 2;

  // apb decode
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire [7:0] ch_off = {3'h0, paddr[4:0]};
  wire ch_sel = paddr[5];
  wire ch_area = (paddr[7:6] == 2'b00) & (ch_off <= `REG_CNT)
    & (paddr[1:0] == 2'b00);
  wire irq_area = (paddr == `REG_IRQ_STAT) | (paddr == `REG_IRQ_EN)
    | (paddr == `REG_IRQ_CLR);
  reg err_q;

  // flattened per-channel views
  wire [NCH*`CTRL_W-1:0] ctrl_f;
  wire [NCH*AW-1:0] src_f, dst_f, ptr_f;
  wire [NCH*CW-1:0] rel_f, cnt_f;
  wire [NCH-1:0] fin_f;
  wire [NCH-1:0] start_f, done_f;
  wire [NCH-1:0] irq_stat, irq_en;

  // sequencer state
  reg [2:0] st_q;
  reg sel_q;
  reg [7:0] lo_q;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      wire hit = wr & ch_area & (ch_sel == g);
      dma_chan #(.AW(AW), .CW(CW)) u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .ctrl_we(hit & (ch_off == `REG_CTRL)),
        .src_we(hit & (ch_off == `REG_SRC_START)),
        .dst_we(hit & (ch_off == `REG_DST_START)),
        .reload_we(hit & (ch_off == `REG_RELOAD)),
        .wdata(pwdata),
        .req_evt(req_evt[g]),
        .xfer_start(start_f[g]),
        .xfer_done(done_f[g]),
        .ctrl(ctrl_f[g*`CTRL_W +: `CTRL_W]),
        .src_start(src_f[g*AW +: AW]),
        .dst_start(dst_f[g*AW +: AW]),
        .reload(rel_f[g*CW +: CW]),
        .ptr(ptr_f[g*AW +: AW]),
        .cnt(cnt_f[g*CW +: CW]),
        .fin(fin_f[g])
      );
    end
  endgenerate

  // channel completion raises a sticky interrupt
  dma_irq #(.N(NCH)) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .evt(fin_f),
    .en_we(wr & (paddr == `REG_IRQ_EN)),
    .clr_we(wr & (paddr == `REG_IRQ_CLR)),
    .wdata(pwdata[NCH-1:0]),
    .status(irq_stat),
    .enable(irq_en),
    .irq(irq)
  );

  // read data is captured in setup so the access phase needs no wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      err_q <= ~(ch_area | irq_area);
      prdata <= 32'h0000_0000;
      if (ch_area) begin
        case (ch_off)
          `REG_CTRL: prdata[`CTRL_W-1:0] <= ctrl_f[ch_sel*`CTRL_W +: `CTRL_W];
          `REG_SRC_START: prdata[AW-1:0] <= src_f[ch_sel*AW +: AW];
          `REG_DST_START: prdata[AW-1:0] <= dst_f[ch_sel*AW +: AW];
          `REG_RELOAD: prdata[CW-1:0] <= rel_f[ch_sel*CW +: CW];
          `REG_PTR: prdata[AW-1:0] <= ptr_f[ch_sel*AW +: AW];
          `REG_CNT: prdata[CW-1:0] <= cnt_f[ch_sel*CW +: CW];
          default: prdata <= 32'h0000_0000;
        endcase
      end else if (paddr == `REG_IRQ_STAT) begin
        prdata[NCH-1:0] <= irq_stat;
      end else if (paddr == `REG_IRQ_EN) begin
        prdata[NCH-1:0] <= irq_en;
      end
    end
  end

  assign pready = 1'b1;
  assign pslverr = acc & err_q;

  // channel 0 wins when both are requesting
  wire go0 = ctrl_f[`BIT_ENABLE] & ctrl_f[`BIT_PENDING];
  wire go1 = ctrl_f[`CTRL_W + `BIT_ENABLE] & ctrl_f[`CTRL_W + `BIT_PENDING];
  wire launch = (st_q == `ST_IDLE) & (go0 | go1);
  assign start_f = launch ? (go0 ? 2'b01 : 2'b10) : 2'b00;
  assign done_f = ((st_q == `ST_WR) & mem_ack) ? (sel_q ? 2'b10 : 2'b01)
    : 2'b00;

  // selected channel addressing; fixed sides use their start value
  wire [`CTRL_W-1:0] cc = ctrl_f[sel_q*`CTRL_W +: `CTRL_W];
  wire [AW-1:0] cptr = ptr_f[sel_q*AW +: AW];
  wire src_is_fwd = cc[`BIT_SRC_FWD];
  wire dst_is_fwd = cc[`BIT_DST_FWD] & ~cc[`BIT_SRC_FWD];
  wire [AW-1:0] src_addr = src_is_fwd ? cptr : src_f[sel_q*AW +: AW];
  wire [AW-1:0] dst_addr = dst_is_fwd ? cptr : dst_f[sel_q*AW +: AW];
  wire odd_split = cc[`BIT_UNIT16] & src_addr[0];

  // transfer sequencer on the memory port
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= `ST_IDLE;
      sel_q <= 1'b0;
      lo_q <= 8'h00;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_wide <= 1'b0;
      mem_addr <= {AW{1'b0}};
      mem_wdata <= 16'h0000;
    end else begin
      case (st_q)
        `ST_IDLE: begin
          if (launch) begin
            sel_q <= ~go0;
            st_q <= `ST_LOAD;
          end
        end
        `ST_LOAD: begin
          // pointer reload has landed; issue the source read
          mem_req <= 1'b1;
          mem_we <= 1'b0;
          mem_addr <= src_addr;
          mem_wide <= cc[`BIT_UNIT16] & ~src_addr[0];
          st_q <= `ST_RD0;
        end
        `ST_RD0: begin
          if (mem_ack) begin
            if (odd_split) begin
              lo_q <= mem_rdata[7:0];
              mem_addr <= src_addr + {{(AW-1){1'b0}}, 1'b1};
              st_q <= `ST_RD1;
            end else begin
              mem_wdata <= mem_rdata;
              mem_we <= 1'b1;
              mem_wide <= cc[`BIT_UNIT16];
              mem_addr <= dst_addr;
              st_q <= `ST_WR;
            end
          end
        end
        `ST_RD1: begin
          if (mem_ack) begin
            mem_wdata <= {mem_rdata[7:0], lo_q};
            mem_we <= 1'b1;
            mem_wide <= 1'b1;
            mem_addr <= dst_addr;
            st_q <= `ST_WR;
          end
        end
        `ST_WR: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            st_q <= `ST_IDLE;
          end
        end
        default: begin
          mem_req <= 1'b0;
          st_q <= `ST_IDLE;
        end
      endcase
    end
  end
endmodule

//--- tb/dma_top_asserts.sv
`timescale 1ns/1ps
module dma_top_asserts #(
  parameter AW = 20,
  parameter CW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire mem_req,
  input wire mem_we,
  input wire mem_wide,
  input wire [AW-1:0] mem_addr,
  input wire [15:0] mem_wdata,
  input wire mem_ack
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // register bus never stalls and refuses misaligned words
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access without ready");
  AST_MISALIGN: assert property (psel && penable && paddr[1:0] != 2'h0
    |-> pslverr) else $error("misaligned access not refused");
  // an error answer belongs to the access phase only
  AST_ERR_ACCESS: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  // memory cycle held until answered, so the far side sees one address
  AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req &&
    $stable(mem_addr) && $stable(mem_we)) else $error("request moved");
  AST_WDATA_HOLD: assert property (mem_req && mem_we && !mem_ack |=>
    $stable(mem_wdata) && $stable(mem_wide)) else $error("write moved");
  AST_WR_DROP: assert property (mem_ack && mem_we |=> !mem_req)
    else $error("request kept after write");
  AST_RD_CHAIN: assert property (mem_req && mem_ack && !mem_we |=> mem_req)
    else $error("no write after read");
  // odd source is never read as one wide cycle
  AST_NO_ODD_WIDE: assert property (
    mem_req && !mem_we && mem_wide |-> !mem_addr[0])
    else $error("wide read at odd address");
  AST_ODD_NEXT: assert property (
    mem_ack && !mem_we ##1 mem_req && !mem_we |-> !mem_wide &&
    mem_addr == $past(mem_addr) + 1'b1) else $error("second read wrong");
  cover property (mem_ack && !mem_we ##1 mem_req && !mem_we);
  cover property (mem_ack && mem_we && mem_wide);
  cover property (pslverr);
endmodule

bind dma_top dma_top_asserts #(.AW(AW), .CW(CW)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
  .mem_we(mem_we), .mem_wide(mem_wide), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack)
);

//--- tb/mem_model.sv
`timescale 1ns/1ps
module mem_model (
  input wire pclk,
  input wire presetn,
  input wire mem_req,
  input wire mem_wide,
  input wire [19:0] mem_addr,
  input wire slow,
  output reg mem_ack,
  output wire [15:0] mem_rdata
);
  reg [1:0] wait_q;
  wire [7:0] lo = mem_addr[7:0] ^ 8'h5a;
  wire [7:0] hi = (mem_addr[7:0] + 8'h01) ^ 8'h5a;
  // data only valid with the answer; inverted otherwise so stale data fails
  assign mem_rdata = mem_ack ? {mem_wide ? hi : 8'h00, lo} : ~{hi, lo};
  // answer after zero or three idle cycles, one pulse per memory cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
    end else begin
      mem_ack <= mem_req && !mem_ack && (wait_q == (slow ? 2'h3 : 2'h0));
      if (!mem_req || mem_ack)
        wait_q <= 2'h0;
      else if (wait_q != 2'h3)
        wait_q <= wait_q + 2'h1;
    end
  end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg pclk, presetn, psel, penable, pwrite, slow, ww, se;
  reg [7:0] paddr;
  reg [31:0] pwdata, rv;
  reg [1:0] req_evt;
  reg [19:0] wa;
  reg [15:0] wd;
  integer err_count, n_checks, wn;
  wire [31:0] prdata;
  wire pready, pslverr, mem_req, mem_we, mem_wide, mem_ack, irq;
  wire [19:0] mem_addr;
  wire [15:0] mem_wdata, mem_rdata;

  dma_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_evt(req_evt),
    .mem_req(mem_req), .mem_we(mem_we), .mem_wide(mem_wide),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .irq(irq)
  );
  mem_model mem (
    .pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_wide(mem_wide), .mem_addr(mem_addr), .slow(slow),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // keep the last completed memory write for later comparison
  always @(posedge pclk) begin
    if (mem_ack && mem_we) begin
      wa <= mem_addr;
      wd <= mem_wdata;
      ww <= mem_wide;
      wn <= wn + 1;
    end
  end

  function [7:0] bt(input [19:0] a);
    bt = a[7:0] ^ 8'h5a;
  endfunction

  task give_verdict;
    begin
      if (err_count == 0 && n_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task bad;
    begin
      err_count = err_count + 1;
      give_verdict;
    end
  endtask

  task chk(input [39:0] got, input [39:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // one transfer; the idle edge first keeps psel from two drives at once
  task bus(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge pclk);
        n = n + 1;
      end
      rv = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
        bad;
    end
  endtask

  task rc(input [7:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk({8'h00, rv}, {8'h00, exp});
    end
  endtask

  task pulse(input integer c);
    begin
      @(posedge pclk);
      req_evt[c] <= 1'b1;
      @(posedge pclk);
      req_evt <= 2'h0;
    end
  endtask

  // wait for the unit's write, then let pointer and counter settle
  task wt;
    integer n, w0;
    begin
      w0 = wn;
      n = 0;
      while (wn == w0 && n < 100) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n >= 100)
        bad;
      repeat (2) @(posedge pclk);
    end
  endtask

  initial begin
    {presetn, psel, penable, pwrite, slow, req_evt} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    n_checks = 0;
    wn = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(8'h00, 32'h0);
    bus(1'b1, 8'h00, 32'h2);
    rc(8'h00, 32'h0);
    bus(1'b1, 8'h04, 32'h101);
    bus(1'b1, 8'h08, 32'h200);
    bus(1'b1, 8'h0c, 32'h2);
    bus(1'b1, 8'h44, 32'h1);
    pulse(0);
    rc(8'h00, 32'h2);
    bus(1'b1, 8'h00, 32'h17);
    wt;
    chk({3'h0, ww, wa, wd}, {4'h1, 20'h200, bt(20'h102), bt(20'h101)});
    rc(8'h10, 32'h103);
    rc(8'h14, 32'h1);
    rc(8'h00, 32'h15);
    bus(1'b1, 8'h04, 32'h300);
    bus(1'b1, 8'h00, 32'h17);
    pulse(0);
    wt;
    chk({3'h0, ww, wa, wd}, {4'h1, 20'h200, bt(20'h301), bt(20'h300)});
    rc(8'h10, 32'h302);
    rc(8'h14, 32'h1);
    pulse(0);
    wt;
    rc(8'h14, 32'h0);
    rc(8'h00, 32'h14);
    chk({39'h0, irq}, 40'h1);
    rc(8'h40, 32'h1);
    bus(1'b1, 8'h44, 32'h0);
    @(posedge pclk);
    chk({39'h0, irq}, 40'h0);
    bus(1'b1, 8'h48, 32'h1);
    rc(8'h40, 32'h0);
    slow <= 1'b1;
    bus(1'b1, 8'h24, 32'h50);
    bus(1'b1, 8'h28, 32'h60);
    bus(1'b1, 8'h2c, 32'h1);
    bus(1'b1, 8'h20, 32'h9);
    pulse(1);
    wt;
    chk({11'h0, ww, wa, wd[7:0]}, {12'h0, 20'h60, bt(20'h50)});
    rc(8'h30, 32'h61);
    rc(8'h34, 32'h0);
    pulse(1);
    rc(8'h20, 32'ha);
    bus(1'b1, 8'h20, 32'h8);
    rc(8'h20, 32'h8);
    bus(1'b0, 8'h4c, 32'h0);
    chk({7'h0, se, rv}, 40'h0100000000);
    bus(1'b1, 8'h02, 32'h1);
    chk({39'h0, se}, 40'h1);
    // a reset in mid-run must bring the working pointers back to zero
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rc(8'h10, 32'h0);
    rc(8'h30, 32'h0);
    rc(8'h40, 32'h0);
    give_verdict;
  end
endmodule
